// ==== rtl/phy_irq_ctrl.sv ====
// interrupt flags, mask, release modes and special control/status register
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - mask holds seven enables at bits 7..1, one enables, all reset to zero
// - one active-low interrupt output asserted by enabled events
// - mode input selects primary (0) or alternate (1) release scheme
// - bits 7..1 map energy, an done, fault, link down, ack, pdf, page
// - flags set on rising source edge, link down on falling link status
// - primary: release on source fall (not link down) or flag read; basic status read for some
// - primary: pdf and page also release on expansion read, restart, link down
// - released energy flag gives 256 ms pulse one second after energy loss
// - energy flag reads one right after reset
// - alternate: clearing an asserted mask bit releases the output at once
// - alternate: host removes the source then writes one to the flag
// - alternate: write-one clears only when the release condition holds
// - special register mirrors an done; its read clears nothing
// - coding enable resets to one; zero bypasses 4b5b, mii only
// - three-bit resolved speed and duplex field, read only
// - scrambler disable bit resets to zero, one disables scrambling
// - flag register shows seven latched flags, other bits zero
module phy_irq_ctrl
  import phy_irq_pkg::*;
#(
  parameter int GLITCH_DELAY_CYCLES = GLITCH_DELAY_CYC,
  parameter int GLITCH_PULSE_CYCLES = GLITCH_PULSE_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire src_s       src,
  input  wire logic       alt_release_mode_select,
  input  wire logic       an_restart,
  input  wire logic [2:0] resolved_speed_duplex,
  input  wire mgmt_req_s  mgmt_req,
  output logic [15:0]     mgmt_rdata,
  output logic            mgmt_hit,
  output logic            irq_out_low,
  output logic            coding_enable,
  output logic            scramble_disable
);

  localparam logic [CNT_W-1:0] DLY_LAST = CNT_W'(GLITCH_DELAY_CYCLES - 1);
  localparam logic [CNT_W-1:0] PLS_LAST = CNT_W'(GLITCH_PULSE_CYCLES - 1);

  main_state_s st_r;
  main_state_s st_nxt;
  logic [7:1]  src_v;
  logic [7:1]  flags;
  logic [7:1]  set_v;
  logic [7:1]  read_clr;
  logic [7:1]  w1c_v;
  logic        rd_flags;
  logic        rd_mask;
  logic        rd_special;
  logic        wr_flags;
  logic        wr_mask;
  logic        wr_special;
  logic        alt_mode;
  logic        glitch_on;

  assign src_v    = src;
  assign alt_mode = alt_release_mode_select;

  // address decode of the management port
  always_comb begin
    rd_flags   = mgmt_req.rd & (mgmt_req.addr == REG_FLAGS);
    rd_mask    = mgmt_req.rd & (mgmt_req.addr == REG_MASK);
    rd_special = mgmt_req.rd & (mgmt_req.addr == REG_SPECIAL);
    wr_flags   = mgmt_req.wr & (mgmt_req.addr == REG_FLAGS);
    wr_mask    = mgmt_req.wr & (mgmt_req.addr == REG_MASK);
    wr_special = mgmt_req.wr & (mgmt_req.addr == REG_SPECIAL);
  end

  // primary-mode release strobes gathered per source
  always_comb begin
    read_clr = '0;
    if (rd_flags) begin
      read_clr = '1;
    end
    if (mgmt_req.rd && mgmt_req.addr == REG_BASIC_STATUS) begin
      read_clr = read_clr | RD_BASIC_CLR;
    end
    if (mgmt_req.rd && mgmt_req.addr == REG_AN_EXPANSION) begin
      read_clr = read_clr | AN_RESTART_CLR;
    end
    if (an_restart || set_v[SRC_LINKDN]) begin
      read_clr = read_clr | AN_RESTART_CLR;
    end
  end

  // alternate-mode write-one strobes, host clears source first
  assign w1c_v = (wr_flags && alt_mode) ? mgmt_req.wdata[7:1] : '0;

  for (genvar i = SRC_LO; i <= SRC_HI; i++) begin : g_flag
    edge_flag_cell #(
      .FALL_SETS   (i == SRC_LINKDN),
      .SRC_RELEASE (SRC_FALL_RELEASE[i]),
      .RESET_FLAG  (FLAG_RST[i])
    ) u_cell (
      .clk      (clk),
      .rst      (rst),
      .src      (src_v[i]),
      .alt_mode (alt_mode),
      .read_clr (read_clr[i]),
      .w1c      (w1c_v[i]),
      .set_evt  (set_v[i]),
      .flag     (flags[i])
    );
  end

  always_comb begin
    st_nxt             = st_r;
    st_nxt.energy_prev = src.energy;
    st_nxt.hit         = mgmt_req.rd & (rd_flags | rd_mask | rd_special);

    if (wr_mask) begin
      st_nxt.mask = mgmt_req.wdata[7:1];
    end
    if (wr_special) begin
      st_nxt.coding_en    = mgmt_req.wdata[SCS_CODING];
      st_nxt.scramble_off = mgmt_req.wdata[SCS_SCRAMBLE];
    end

    if (mgmt_req.rd) begin
      unique case (1'b1)
        rd_flags: begin
          st_nxt.rdata = {8'h00, flags, 1'h0};
        end
        rd_mask: begin
          st_nxt.rdata = {8'h00, st_r.mask, 1'h0};
        end
        rd_special: begin
          st_nxt.rdata = {3'h0, src.an_done, 2'h0, 3'h0, st_r.coding_en, 1'h0,
                          resolved_speed_duplex, 1'h0, st_r.scramble_off};
        end
        default: begin
          st_nxt.rdata = 16'h0000;
        end
      endcase
    end

    // energy flag released by a read while energy is still present
    if (!alt_mode && read_clr[SRC_ENERGY] && flags[SRC_ENERGY] && src.energy
        && st_r.mask[SRC_ENERGY] && !set_v[SRC_ENERGY]) begin
      st_nxt.armed = 1'b1;
    end

    unique case (st_r.gl)
      GL_IDLE: begin
        if (st_r.armed && st_r.energy_prev && !src.energy) begin
          st_nxt.gl     = GL_WAIT;
          st_nxt.gl_cnt = '0;
          st_nxt.armed  = 1'b0;
        end
      end
      GL_WAIT: begin
        st_nxt.gl_cnt = st_r.gl_cnt + 1'b1;
        if (st_r.gl_cnt == DLY_LAST) begin
          st_nxt.gl     = GL_PULSE;
          st_nxt.gl_cnt = '0;
        end
      end
      GL_PULSE: begin
        st_nxt.gl_cnt = st_r.gl_cnt + 1'b1;
        if (st_r.gl_cnt == PLS_LAST) begin
          st_nxt.gl     = GL_IDLE;
          st_nxt.gl_cnt = '0;
        end
      end
      default: begin
        st_nxt.gl     = GL_IDLE;
        st_nxt.gl_cnt = '0;
      end
    endcase

    // a cleared energy mask drops any pending or running glitch
    if (!st_nxt.mask[SRC_ENERGY]) begin
      st_nxt.armed  = 1'b0;
      st_nxt.gl     = GL_IDLE;
      st_nxt.gl_cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{mask: MASK_RST, coding_en: CODING_RST, scramble_off: SCRAMBLE_RST,
                rdata: 16'h0000, hit: 1'b0, gl: GL_IDLE, gl_cnt: '0,
                armed: 1'b0, energy_prev: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign glitch_on = (st_r.gl == GL_PULSE) & st_r.mask[SRC_ENERGY];

  // combinational, so a mask clear releases the pin at once
  assign irq_out_low      = ~(|(flags & st_r.mask) | glitch_on);
  assign mgmt_rdata       = st_r.rdata;
  assign mgmt_hit         = st_r.hit;
  assign coding_enable    = st_r.coding_en;
  assign scramble_disable = st_r.scramble_off;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  mask_write_a: assert property (
    wr_mask |=> st_r.mask == $past(mgmt_req.wdata[7:1])
  ) else $error("mask register did not take the written bits");

  mask_reserved_a: assert property (
    rd_mask |=> mgmt_rdata[15:8] == 8'h00 && mgmt_rdata[0] == 1'b0
  ) else $error("reserved mask bits read nonzero");

  irq_assert_a: assert property (
    (|(flags & st_r.mask)) |-> !irq_out_low
  ) else $error("enabled flag without interrupt output");

  irq_quiet_a: assert property (
    (flags & st_r.mask) == 7'h00 && st_r.gl != GL_PULSE |-> irq_out_low
  ) else $error("interrupt output low with no enabled flag");

  andone_set_a: assert property (
    $rose(src.an_done) |-> ##1 flags[SRC_ANDONE]
  ) else $error("auto-negotiation flag not set on rising source");

  link_set_a: assert property (
    $fell(src.link) |=> flags[SRC_LINKDN] && !irq_out_low == st_r.mask[SRC_LINKDN]
      || flags[SRC_LINKDN] && (st_r.mask[SRC_LINKDN] || glitch_on || |(flags & st_r.mask))
  ) else $error("link down flag not set on falling link status");

  primary_read_a: assert property (
    !alt_mode && rd_flags && set_v == 7'h00 |=> flags == 7'h00
  ) else $error("flag register read did not release flags");

  restart_clear_a: assert property (
    !alt_mode && an_restart && !set_v[SRC_PDF] && !set_v[SRC_PAGE]
      |=> !flags[SRC_PDF] && !flags[SRC_PAGE]
  ) else $error("restart did not release detection and page flags");

  alt_hold_a: assert property (
    alt_mode && flags[SRC_ANDONE] && src.an_done |=> flags[SRC_ANDONE]
  ) else $error("alternate flag released while source still high");

  alt_w1c_a: assert property (
    alt_mode && w1c_v[SRC_ACK] && !src.ack |=> !flags[SRC_ACK]
  ) else $error("write one did not release a quiet source");

  alt_mask_a: assert property (
    alt_mode && wr_mask && mgmt_req.wdata[7:1] == 7'h00 |=> irq_out_low
  ) else $error("clearing the mask did not release the output");

  special_read_a: assert property (
    rd_special |=> mgmt_rdata[4:2] == $past(resolved_speed_duplex)
      && mgmt_rdata[SCS_AUTODONE] == $past(src.an_done)
  ) else $error("special register read mismatch");

  special_noclr_a: assert property (
    !alt_mode && rd_special && flags[SRC_ANDONE] && src.an_done |=> flags[SRC_ANDONE]
  ) else $error("special register read cleared a flag");

  ctrl_write_a: assert property (
    wr_special |=> scramble_disable == $past(mgmt_req.wdata[SCS_SCRAMBLE])
      && coding_enable == $past(mgmt_req.wdata[SCS_CODING])
  ) else $error("control bits did not follow the write");

  energy_reset_a: assert property (
    $past(rst) |-> flags[SRC_ENERGY]
  ) else $error("energy flag not one after reset");

  glitch_wait_a: assert property (
    st_r.gl == GL_IDLE && st_r.armed && st_r.energy_prev && !src.energy
      && st_nxt.mask[SRC_ENERGY] |=> st_r.gl == GL_WAIT && st_r.gl_cnt == '0
  ) else $error("energy loss did not start glitch delay");

  glitch_pulse_a: assert property (
    st_r.gl == GL_WAIT && st_r.gl_cnt == DLY_LAST && st_r.mask[SRC_ENERGY]
      && st_nxt.mask[SRC_ENERGY] |=> !irq_out_low
  ) else $error("glitch pulse did not assert the output");

  flags_read_a: assert property (
    rd_flags |=> mgmt_hit && mgmt_rdata == {8'h00, $past(flags), 1'b0}
  ) else $error("flag register read returned wrong word");

  other_read_a: assert property (
    mgmt_req.rd && !(rd_flags || rd_mask || rd_special) |=> !mgmt_hit && mgmt_rdata == 16'h0000
  ) else $error("foreign address answered a read");

  src_fall_a: assert property (
    !alt_mode && $fell(src.ack) |=> !flags[SRC_ACK]
  ) else $error("falling source did not release its flag");

  link_hold_a: assert property (
    !alt_mode && flags[SRC_LINKDN] && !mgmt_req.rd |=> flags[SRC_LINKDN]
  ) else $error("link down flag released without a read");

  basic_read_a: assert property (
    !alt_mode && mgmt_req.rd && mgmt_req.addr == REG_BASIC_STATUS
      && !set_v[SRC_RFAULT] && !set_v[SRC_LINKDN] |=> !flags[SRC_RFAULT] && !flags[SRC_LINKDN]
  ) else $error("basic status read did not release fault and link flags");

  expansion_read_a: assert property (
    !alt_mode && mgmt_req.rd && mgmt_req.addr == REG_AN_EXPANSION
      && !set_v[SRC_PDF] && !set_v[SRC_PAGE] |=> !flags[SRC_PDF] && !flags[SRC_PAGE]
  ) else $error("expansion read did not release detection and page flags");

  linkdn_clear_a: assert property (
    !alt_mode && set_v[SRC_LINKDN] && !set_v[SRC_PDF] && !set_v[SRC_PAGE]
      |=> !flags[SRC_PDF] && !flags[SRC_PAGE]
  ) else $error("link down did not release detection and page flags");

  alt_noread_a: assert property (
    alt_mode && rd_flags && !wr_flags && flags[SRC_ANDONE] |=> flags[SRC_ANDONE]
  ) else $error("alternate flag released by a read");

  alt_link_a: assert property (
    alt_mode && flags[SRC_LINKDN] && w1c_v[SRC_LINKDN] && !src.link |=> flags[SRC_LINKDN]
  ) else $error("link down flag released while link still down");

  alt_clear_a: assert property (
    alt_mode && wr_mask && (flags & mgmt_req.wdata[7:1]) == 7'h00 && set_v == 7'h00
      && st_r.gl == GL_IDLE |=> irq_out_low
  ) else $error("output stayed low after its mask bits were cleared");

  glitch_end_a: assert property (
    st_r.gl == GL_PULSE && st_r.gl_cnt == PLS_LAST |=> st_r.gl == GL_IDLE
  ) else $error("glitch pulse ran past its length");

  glitch_abort_a: assert property (
    (st_r.armed || st_r.gl != GL_IDLE) && wr_mask && !mgmt_req.wdata[SRC_ENERGY]
      |=> st_r.gl == GL_IDLE && !st_r.armed
  ) else $error("clearing the energy mask left a glitch pending");

  reset_values_a: assert property (
    $past(rst) |-> coding_enable && !scramble_disable && st_r.mask == 7'h00 && irq_out_low
  ) else $error("control bits or mask wrong after reset");

  primary_read_c: cover property (!alt_mode && rd_flags && flags != 7'h00);
  alt_release_c:  cover property (alt_mode && |w1c_v ##1 irq_out_low);
  glitch_c:       cover property (st_r.gl == GL_WAIT ##1 st_r.gl == GL_PULSE);
  mask_irq_c:     cover property (wr_mask ##1 !irq_out_low);
  alt_unmask_c:   cover property (alt_mode && wr_mask && !irq_out_low ##1 irq_out_low);

endmodule : phy_irq_ctrl
`default_nettype wire

// ==== pkg/phy_irq_pkg.sv ====
// shared constants and types for the phy interrupt and special status block
package phy_irq_pkg;

  // register addresses on the serial management port
  localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
  localparam logic [4:0] REG_AN_EXPANSION = 5'h06;
  localparam logic [4:0] REG_FLAGS        = 5'h1D;
  localparam logic [4:0] REG_MASK         = 5'h1E;
  localparam logic [4:0] REG_SPECIAL      = 5'h1F;

  // source positions in flag and mask registers
  localparam int SRC_LO     = 1;
  localparam int SRC_HI     = 7;
  localparam int SRC_ENERGY = 7;
  localparam int SRC_ANDONE = 6;
  localparam int SRC_RFAULT = 5;
  localparam int SRC_LINKDN = 4;
  localparam int SRC_ACK    = 3;
  localparam int SRC_PDF    = 2;
  localparam int SRC_PAGE   = 1;

  // reset values and per-source release sets, indexed [7:1]
  localparam logic [7:1] MASK_RST         = 7'h00;
  localparam logic [7:1] FLAG_RST         = 7'h40;
  localparam logic [7:1] SRC_FALL_RELEASE = 7'h77;
  localparam logic [7:1] RD_BASIC_CLR     = 7'h18;
  localparam logic [7:1] AN_RESTART_CLR   = 7'h03;
  localparam logic       CODING_RST       = 1'h1;
  localparam logic       SCRAMBLE_RST     = 1'h0;

  // special control/status field positions
  localparam int SCS_AUTODONE  = 12;
  localparam int SCS_CODING    = 6;
  localparam int SCS_SCRAMBLE  = 0;

  // resolved speed and duplex codes
  localparam logic [2:0] SPD_10_HALF  = 3'h1;
  localparam logic [2:0] SPD_10_FULL  = 3'h5;
  localparam logic [2:0] SPD_100_HALF = 3'h2;
  localparam logic [2:0] SPD_100_FULL = 3'h6;

  // energy glitch timing
  localparam int CLK_FREQ_HZ       = 200_000_000;
  localparam int GLITCH_DELAY_MS   = 1000;
  localparam int GLITCH_PULSE_MS   = 256;
  localparam int GLITCH_DELAY_CYC  = (CLK_FREQ_HZ / 1000) * GLITCH_DELAY_MS;
  localparam int GLITCH_PULSE_CYC  = (CLK_FREQ_HZ / 1000) * GLITCH_PULSE_MS;
  localparam int CNT_W             = 28;

  typedef enum logic [2:0] {
    GL_IDLE  = 3'h1,
    GL_WAIT  = 3'h2,
    GL_PULSE = 3'h4
  } glitch_e;

  // source status levels, energy in the top bit
  typedef struct packed {
    logic energy;
    logic an_done;
    logic rfault;
    logic link;
    logic ack;
    logic pdf;
    logic page;
  } src_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mgmt_req_s;

  typedef struct packed {
    logic prev;
    logic flag;
  } cell_state_s;

  typedef struct packed {
    logic [7:1]       mask;
    logic             coding_en;
    logic             scramble_off;
    logic [15:0]      rdata;
    logic             hit;
    glitch_e          gl;
    logic [CNT_W-1:0] gl_cnt;
    logic             armed;
    logic             energy_prev;
  } main_state_s;

endpackage : phy_irq_pkg

// ==== rtl/edge_flag_cell.sv ====
// one latched interrupt source flag with primary and alternate release
`timescale 1ns/1ps
`default_nettype none
module edge_flag_cell
  import phy_irq_pkg::*;
#(
  parameter bit FALL_SETS   = 1'b0,
  parameter bit SRC_RELEASE = 1'b1,
  parameter bit RESET_FLAG  = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic src,
  input  wire logic alt_mode,
  input  wire logic read_clr,
  input  wire logic w1c,
  output logic      set_evt,
  output logic      flag
);

  cell_state_s st_r;
  cell_state_s st_nxt;
  logic        active;
  logic        fall;
  logic        release_evt;

  always_comb begin
    active  = src ^ FALL_SETS;
    set_evt = active & ~st_r.prev;
    fall    = ~active & st_r.prev;
    if (alt_mode) begin
      release_evt = w1c & ~active;
    end else begin
      release_evt = (fall & SRC_RELEASE) | read_clr;
    end
    st_nxt      = st_r;
    st_nxt.prev = active;
    // a new edge beats any release in the same cycle
    if (set_evt) begin
      st_nxt.flag = 1'b1;
    end else if (release_evt) begin
      st_nxt.flag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{prev: RESET_FLAG, flag: RESET_FLAG};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag;

endmodule : edge_flag_cell
`default_nettype wire

// ==== testbench/mgmt_host_model.sv ====
// management host model on the register port, watching the interrupt line
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model
  import phy_irq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [15:0] mgmt_rdata,
  input  wire logic        mgmt_hit,
  input  wire logic        irq_out_low,
  output var mgmt_req_s    req
);
  initial req = '0;

  // one strobe edge, answer taken one cycle later
  task automatic access(input logic rd, input logic wr, input logic [4:0] addr,
                        input logic [15:0] wdata, output logic [15:0] rdata,
                        output logic hit);
    @(negedge clk);
    req = '{rd: rd, wr: wr, addr: addr, wdata: wdata};
    @(negedge clk);
    rdata = mgmt_rdata;
    hit   = mgmt_hit;
    // idle address and data lines show the inverse, never the last value; strobes drop to zero
    req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask : access

  // energy service routine: read flags, then drop the energy enable
  task automatic service_energy(output logic [15:0] flags, output logic served);
    logic        h;
    logic [15:0] m;
    served = (irq_out_low === 1'b0);
    flags  = 16'h0000;
    if (served) begin
      access(1'b1, 1'b0, REG_FLAGS, 16'h0000, flags, h);
      access(1'b1, 1'b0, REG_MASK, 16'h0000, m, h);
      access(1'b0, 1'b1, REG_MASK, m & ~16'h0080, m, h);
    end
  endtask : service_energy
endmodule : mgmt_host_model
`default_nettype wire

// ==== testbench/tb.sv ====
// testbench for the interrupt flags, mask and special status block
`timescale 1ns/1ps
`default_nettype none
module tb
  import phy_irq_pkg::*;
;
  logic        clk, rst, alt, restart, h, served;
  logic [7:1]  lvl;
  logic [2:0]  spd;
  src_s        src_w;
  mgmt_req_s   req;
  logic [15:0] rdata, d;
  logic        hit, irq_out_low, coding, scr_off;
  int          errors, checks_done, n, first;
  int          ps[5] = '{6, 5, 3, 2, 1};
  logic [2:0]  codes[4] = '{SPD_10_HALF, SPD_10_FULL, SPD_100_HALF, SPD_100_FULL};

  assign src_w = src_s'(lvl);
  always #2.5 clk = ~clk;

  phy_irq_ctrl #(.GLITCH_DELAY_CYCLES(20), .GLITCH_PULSE_CYCLES(8)) i_dut (
    .clk(clk), .rst(rst), .src(src_w), .alt_release_mode_select(alt),
    .an_restart(restart), .resolved_speed_duplex(spd), .mgmt_req(req),
    .mgmt_rdata(rdata), .mgmt_hit(hit), .irq_out_low(irq_out_low),
    .coding_enable(coding), .scramble_disable(scr_off));

  mgmt_host_model i_host (.clk(clk), .mgmt_rdata(rdata), .mgmt_hit(hit),
    .irq_out_low(irq_out_low), .req(req));

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    i_host.access(1'b1, 1'b0, a, 16'h0000, d, h);
    check(d, exp, "read data");
    check({15'h0, h}, {15'h0, a >= REG_FLAGS}, "hit flag");
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    i_host.access(1'b0, 1'b1, a, v, d, h);
  endtask : wr

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  task automatic irq(input logic e);
    check({15'h0, irq_out_low}, {15'h0, e}, "interrupt level");
  endtask : irq

  task automatic set(input int p, input logic v);
    lvl[p] = v;
    cyc(2);
  endtask : set

  function automatic logic [15:0] sp(input logic ad, input logic [2:0] s, input logic c,
                                     input logic x);
    return {3'h0, ad, 5'h00, c, 1'b0, s, 1'b0, x};
  endfunction : sp

  task automatic summarize();
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    clk = 0; rst = 1; alt = 0; restart = 0; lvl = 7'h48; spd = SPD_100_FULL;
    errors = 0; checks_done = 0;
    cyc(20);
    rst = 0;
    irq(1'b1);
    check({14'h0, coding, scr_off}, 16'h0002, "control outputs");
    rd(REG_SPECIAL, sp(1'b0, SPD_100_FULL, 1'b1, 1'b0));
    rd(REG_MASK, 16'h0000);
    rd(REG_FLAGS, 16'h0080);
    rd(REG_FLAGS, 16'h0000);
    foreach (codes[i]) begin
      spd = codes[i];
      rd(REG_SPECIAL, sp(1'b0, codes[i], 1'b1, 1'b0));
    end
    wr(REG_MASK, 16'hFFFF);
    rd(REG_MASK, 16'h00FE);
    wr(REG_SPECIAL, 16'hFFFF);
    rd(REG_SPECIAL, sp(1'b0, spd, 1'b1, 1'b1));
    wr(REG_SPECIAL, 16'h0000);
    check({14'h0, coding, scr_off}, 16'h0000, "control outputs");
    wr(REG_SPECIAL, 16'h0040);
    set(6, 1'b1);
    irq(1'b0);
    rd(REG_SPECIAL, sp(1'b1, spd, 1'b1, 1'b0));
    irq(1'b0);
    rd(REG_FLAGS, 16'h0040);
    irq(1'b1);
    set(6, 1'b0);
    foreach (ps[i]) begin
      set(ps[i], 1'b1);
      irq(1'b0);
      set(ps[i], 1'b0);
      irq(1'b1);
      set(ps[i], 1'b1);
      if (ps[i] == 5) rd(REG_BASIC_STATUS, 16'h0000);
      else if (ps[i] <= 2) rd(REG_AN_EXPANSION, 16'h0000);
      else rd(REG_FLAGS, 16'h0001 << ps[i]);
      irq(1'b1);
      set(ps[i], 1'b0);
    end
    set(2, 1'b1);
    restart = 1;
    cyc(1);
    restart = 0;
    cyc(1);
    irq(1'b1);
    set(2, 1'b0);
    set(1, 1'b1);
    set(4, 1'b0);
    rd(REG_FLAGS, 16'h0010);
    set(4, 1'b1);
    set(4, 1'b0);
    set(4, 1'b1);
    irq(1'b0);
    rd(REG_BASIC_STATUS, 16'h0000);
    irq(1'b1);
    set(1, 1'b0);
    wr(REG_MASK, 16'h0000);
    set(3, 1'b1);
    irq(1'b1);
    wr(REG_FLAGS, 16'h00FE);
    rd(REG_FLAGS, 16'h0008);
    set(3, 1'b0);
    alt = 1;
    wr(REG_MASK, 16'h00FE);
    set(6, 1'b1);
    irq(1'b0);
    wr(REG_MASK, 16'h0000);
    irq(1'b1);
    wr(REG_MASK, 16'h00FE);
    irq(1'b0);
    rd(REG_FLAGS, 16'h0040);
    wr(REG_FLAGS, 16'h0040);
    irq(1'b0);
    set(6, 1'b0);
    irq(1'b0);
    wr(REG_FLAGS, 16'h0040);
    irq(1'b1);
    set(3, 1'b1);
    wr(REG_MASK, 16'h00F6);
    irq(1'b1);
    rd(REG_FLAGS, 16'h0008);
    set(4, 1'b0);
    irq(1'b0);
    wr(REG_FLAGS, 16'h0010);
    irq(1'b0);
    set(4, 1'b1);
    wr(REG_FLAGS, 16'h0018);
    set(3, 1'b0);
    wr(REG_FLAGS, 16'h0008);
    rd(REG_FLAGS, 16'h0000);
    alt = 0;
    wr(REG_MASK, 16'h0080);
    set(7, 1'b0);
    set(7, 1'b1);
    irq(1'b0);
    rd(REG_FLAGS, 16'h0080);
    irq(1'b1);
    lvl[7] = 1'b0;
    n = 0;
    first = -1;
    for (int i = 0; i < 60; i++) begin
      cyc(1);
      if (irq_out_low === 1'b0) begin
        n++;
        if (first < 0) first = i;
      end
    end
    check(16'(n), 16'd8, "glitch pulse length");
    check({15'h0, first >= 18 && first <= 23}, 16'h0001, "glitch pulse delay");
    set(7, 1'b1);
    i_host.service_energy(d, served);
    check({15'h0, served}, 16'h0001, "service entered");
    check(d, 16'h0080, "serviced flags");
    lvl[7] = 1'b0;
    n = 0;
    for (int i = 0; i < 60; i++) begin
      cyc(1);
      if (irq_out_low !== 1'b1) n++;
    end
    check(16'(n), 16'd0, "no glitch after mask clear");
    summarize();
  end
endmodule : tb
`default_nettype wire
